/* core/static_memory_params.svh */
// Constants for the static memory page read controller.
`ifndef STATIC_MEMORY_PARAMS_SVH
`define STATIC_MEMORY_PARAMS_SVH

`define OFS_SETUP        4'h0
`define OFS_PULSE        4'h4
`define OFS_CYCLE        4'h8
`define OFS_MODE         4'hC
`define CS_STRIDE        8'h10
`define OFS_STATUS       8'h80
`define RST_SETUP        32'h00000000
`define RST_PULSE        32'h01010101
`define RST_CYCLE        32'h00010001
`define RST_MODE         32'h10001000

`define MODE_BAT         8
`define MODE_DBW_LO      12
`define MODE_PAGE_BURST_ENABLE        24
`define MODE_PS_LO       28

`define SLOW_RD_SETUP    10'h001
`define SLOW_RD_PULSE    10'h001
`define SLOW_CS_RD_SETUP 10'h000
`define SLOW_CS_RD_PULSE 10'h002
`define SLOW_RD_CYCLE    10'h002
`define SLOW_WR_SETUP    10'h001
`define SLOW_WR_PULSE    10'h001
`define SLOW_CS_WR_SETUP 10'h000
`define SLOW_CS_WR_PULSE 10'h003
`define SLOW_WR_CYCLE    10'h003

`endif

/* core/static_memory_pkg.sv */
// Types shared by the static memory page read controller.
package static_memory_pkg;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [2:0]  cs;
		logic [25:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] rdata;
	} mem_rsp_t;

	typedef struct packed {
		logic [9:0] cs_setup;
		logic [9:0] cs_pulse;
		logic [9:0] st_setup;
		logic [9:0] st_pulse;
		logic [9:0] total;
	} wave_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_PAGE_RUN,
		ST_PAGE_OPEN
	} seq_state_t;

endpackage

/* core/static_memory_page_read_ctrl.sv */
// Static memory controller with per-chip-select timing and page-mode reads.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "static_memory_params.svh"

module static_memory_page_read_ctrl (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      slow_clock_mode,
	input  wire logic                      other_access,
	input  wire static_memory_pkg::mem_req_t req,
	output logic                           req_ready,
	output static_memory_pkg::mem_rsp_t    rsp,
	output logic [7:0]                     chip_select_n,
	output logic                           read_strobe_n,
	output logic                           write_strobe_n,
	output logic [3:0]                     byte_sel_n,
	output logic [3:0]                     write_byte_n,
	output logic [25:0]                    mem_addr,
	output logic [31:0]                    mem_wdata,
	output logic                           mem_data_oe,
	input  wire logic [31:0]               mem_rdata
);
	import static_memory_pkg::*;

	// ****************************************************************
	// Field decoding.
	// ****************************************************************
	function automatic logic [9:0] setup_len(input logic [5:0] f);
		setup_len = {2'b00, f[5], 2'b00, f[4:0]};
	endfunction

	function automatic logic [9:0] pulse_len(input logic [6:0] f);
		pulse_len = {1'b0, f[6], 2'b00, f[5:0]};
	endfunction

	function automatic logic [9:0] cycle_len(input logic [8:0] f);
		cycle_len = {f[8:7], 1'b0, f[6:0]};
	endfunction

	function automatic logic [9:0] at_least_one(input logic [9:0] v);
		at_least_one = (v == 10'h000) ? 10'h001 : v;
	endfunction

	// Page address: bits below 2 + page size are the in-page offset.
	function automatic logic [25:0] page_of(input logic [25:0] a,
		input logic [1:0] ps);
		page_of = a & ~((26'h0000004 << ps) - 26'h0000001);
	endfunction

	// ****************************************************************
	// Register file.
	// ****************************************************************
	logic [31:0] staged_setup [8];
	logic [31:0] staged_pulse [8];
	logic [31:0] staged_cycle [8];
	logic [31:0] mode         [8];
	logic [31:0] act_setup    [8];
	logic [31:0] act_pulse    [8];
	logic [31:0] act_cycle    [8];

	seq_state_t  state;
	logic        page_valid;
	logic [2:0]  page_cs;
	logic [25:0] page_addr;

	logic        wr_en;
	logic        rd_setup;
	logic [2:0]  reg_cs;
	logic [3:0]  reg_ofs;
	logic        mapped;
	logic [31:0] next_prdata;

	assign wr_en    = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign reg_cs   = paddr[6:4];
	assign reg_ofs  = paddr[3:0];
	assign mapped   = (paddr[7] == 1'b0) || (paddr == `OFS_STATUS);
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !mapped;

	always_comb begin
		next_prdata = 32'h00000000;
		if (paddr == `OFS_STATUS) begin
			next_prdata = {28'h0000000, slow_clock_mode, page_valid,
				state == ST_PAGE_OPEN, state != ST_IDLE};
		end else if (paddr[7]) begin
			next_prdata = 32'h00000000;
		end else if (reg_ofs == `OFS_SETUP) begin
			next_prdata = staged_setup[reg_cs];
		end else if (reg_ofs == `OFS_PULSE) begin
			next_prdata = staged_pulse[reg_cs];
		end else if (reg_ofs == `OFS_CYCLE) begin
			next_prdata = staged_cycle[reg_cs];
		end else if (reg_ofs == `OFS_MODE) begin
			next_prdata = mode[reg_cs];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= next_prdata;
		end
	end

	// Eight groups of four registers at a 0x10 stride.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				staged_setup[i] <= `RST_SETUP;
				staged_pulse[i] <= `RST_PULSE;
				staged_cycle[i] <= `RST_CYCLE;
				mode[i]         <= `RST_MODE;
			end
		end else if (wr_en && !paddr[7]) begin
			if (reg_ofs == `OFS_SETUP) begin
				staged_setup[reg_cs] <= pwdata;
			end else if (reg_ofs == `OFS_PULSE) begin
				staged_pulse[reg_cs] <= pwdata;
			end else if (reg_ofs == `OFS_CYCLE) begin
				staged_cycle[reg_cs] <= pwdata;
			end else if (reg_ofs == `OFS_MODE) begin
				mode[reg_cs] <= pwdata;
			end
		end
	end

	// Timings written so far go live together on any mode register write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				act_setup[i] <= `RST_SETUP;
				act_pulse[i] <= `RST_PULSE;
				act_cycle[i] <= `RST_CYCLE;
			end
		end else if (wr_en && !paddr[7] && reg_ofs == `OFS_MODE) begin
			for (int i = 0; i < 8; i++) begin
				act_setup[i] <= staged_setup[i];
				act_pulse[i] <= staged_pulse[i];
				act_cycle[i] <= staged_cycle[i];
			end
		end
	end

	// ****************************************************************
	// Waveform selection for a new request.
	// ****************************************************************
	logic [31:0] sel_setup;
	logic [31:0] sel_pulse;
	logic [31:0] sel_cycle;
	logic [31:0] sel_mode;
	logic        page_req;
	logic        page_hit;
	wave_t       next_wave;

	assign sel_setup = act_setup[req.cs];
	assign sel_pulse = act_pulse[req.cs];
	assign sel_cycle = act_cycle[req.cs];
	assign sel_mode  = mode[req.cs];
	assign page_req  = !req.write && sel_mode[`MODE_PAGE_BURST_ENABLE]
		&& !slow_clock_mode;
	assign page_hit  = page_valid && page_cs == req.cs && page_addr
		== page_of(req.addr, sel_mode[`MODE_PS_LO +: 2]);

	always_comb begin
		next_wave = '0;
		if (slow_clock_mode && req.write) begin
			next_wave.cs_setup = `SLOW_CS_WR_SETUP;
			next_wave.cs_pulse = `SLOW_CS_WR_PULSE;
			next_wave.st_setup = `SLOW_WR_SETUP;
			next_wave.st_pulse = `SLOW_WR_PULSE;
			next_wave.total    = `SLOW_WR_CYCLE;
		end else if (slow_clock_mode) begin
			next_wave.cs_setup = `SLOW_CS_RD_SETUP;
			next_wave.cs_pulse = `SLOW_CS_RD_PULSE;
			next_wave.st_setup = `SLOW_RD_SETUP;
			next_wave.st_pulse = `SLOW_RD_PULSE;
			next_wave.total    = `SLOW_RD_CYCLE;
		end else if (page_req) begin
			// Setups, read mode and total length play no part here.
			next_wave.st_pulse = at_least_one(page_hit
				? pulse_len(sel_pulse[22:16])
				: pulse_len(sel_pulse[30:24]));
			next_wave.cs_pulse = next_wave.st_pulse;
			next_wave.total    = next_wave.st_pulse;
		end else if (req.write) begin
			next_wave.cs_setup = setup_len(sel_setup[13:8]);
			next_wave.cs_pulse = pulse_len(sel_pulse[14:8]);
			next_wave.st_setup = setup_len(sel_setup[5:0]);
			next_wave.st_pulse = pulse_len(sel_pulse[6:0]);
			next_wave.total    = at_least_one(cycle_len(sel_cycle[8:0]));
		end else begin
			next_wave.cs_setup = setup_len(sel_setup[29:24]);
			next_wave.cs_pulse = pulse_len(sel_pulse[30:24]);
			next_wave.st_setup = setup_len(sel_setup[21:16]);
			next_wave.st_pulse = pulse_len(sel_pulse[22:16]);
			next_wave.total    = at_least_one(cycle_len(sel_cycle[24:16]));
		end
	end

	// ****************************************************************
	// Access sequencer.
	// ****************************************************************
	wave_t       wave;
	logic [9:0]  cnt;
	logic        cur_write;
	logic [2:0]  cur_cs;
	logic [3:0]  cur_be;
	logic        cur_bat;
	logic        last_cycle;
	logic        sample_cycle;
	logic        take;
	logic        release_page;
	logic        sample_late;
	logic        done_late;

	assign last_cycle   = (cnt == wave.total - 10'h001);
	assign sample_cycle = (cnt == wave.st_setup + wave.st_pulse - 10'h001);
	assign release_page = other_access || slow_clock_mode
		|| (req.valid && !(page_req && page_hit));

	always_comb begin
		req_ready = 1'b0;
		if (state == ST_IDLE) begin
			req_ready = !other_access;
		end else if (state == ST_PAGE_OPEN) begin
			req_ready = !release_page;
		end
	end
	assign take = req.valid && req_ready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			cnt   <= 10'h000;
		end else begin
			case (state)
				ST_IDLE: begin
					cnt <= 10'h000;
					if (take) begin
						state <= page_req ? ST_PAGE_RUN : ST_RUN;
					end
				end
				ST_RUN: begin
					cnt <= cnt + 10'h001;
					if (last_cycle) begin
						state <= ST_IDLE;
					end
				end
				ST_PAGE_RUN: begin
					cnt <= cnt + 10'h001;
					if (last_cycle) begin
						state <= ST_PAGE_OPEN;
					end
				end
				ST_PAGE_OPEN: begin
					cnt <= 10'h000;
					if (take) begin
						state <= ST_PAGE_RUN;
					end else if (release_page) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// The waveform is frozen at the start, so a slow clock exit mid
	// transfer still completes with the slow set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave      <= '0;
			cur_write <= 1'b0;
			cur_cs    <= 3'h0;
			cur_be    <= 4'h0;
			cur_bat   <= 1'b0;
			mem_addr  <= 26'h0000000;
			mem_wdata <= 32'h00000000;
		end else if (take) begin
			wave      <= next_wave;
			cur_write <= req.write;
			cur_cs    <= req.cs;
			cur_be    <= req.be;
			cur_bat   <= sel_mode[`MODE_BAT];
			mem_wdata <= req.wdata;
			if (sel_mode[`MODE_DBW_LO +: 2] == 2'b01) begin
				mem_addr <= {req.addr[25:1], 1'b0};
			end else if (sel_mode[`MODE_DBW_LO +: 2] == 2'b10) begin
				mem_addr <= {req.addr[25:2], 2'b00};
			end else begin
				mem_addr <= req.addr;
			end
		end
	end

	// Page record; dropped whenever chip select is released.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_valid <= 1'b0;
			page_cs    <= 3'h0;
			page_addr  <= 26'h0000000;
		end else if (take && page_req) begin
			page_valid <= 1'b1;
			page_cs    <= req.cs;
			page_addr  <= page_of(req.addr, sel_mode[`MODE_PS_LO +: 2]);
		end else if (state == ST_PAGE_OPEN && release_page) begin
			page_valid <= 1'b0;
		end else if (state == ST_IDLE || state == ST_RUN) begin
			page_valid <= 1'b0;
		end
	end

	// ****************************************************************
	// Response.
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp         <= '0;
			sample_late <= 1'b0;
			done_late   <= 1'b0;
		end else begin
			// Strobes lag the counter by a cycle, so data is taken a
			// cycle late, while the strobe is still low.
			sample_late <= !cur_write && (state == ST_PAGE_RUN
				? last_cycle : (state == ST_RUN && sample_cycle));
			done_late   <= (state == ST_RUN || state == ST_PAGE_RUN)
				&& last_cycle;
			rsp.valid   <= done_late;
			if (sample_late) begin
				rsp.rdata <= mem_rdata;
			end
		end
	end

	// ****************************************************************
	// Memory strobes, registered one cycle after the counter.
	// ****************************************************************
	logic cs_on;
	logic st_on;

	assign cs_on = (state == ST_PAGE_RUN) || (state == ST_PAGE_OPEN)
		|| (state == ST_RUN && cnt >= wave.cs_setup
		&& cnt < wave.cs_setup + wave.cs_pulse);
	assign st_on = (state == ST_PAGE_RUN) || (state == ST_PAGE_OPEN)
		|| (state == ST_RUN && cnt >= wave.st_setup
		&& cnt < wave.st_setup + wave.st_pulse);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chip_select_n  <= 8'hFF;
			read_strobe_n  <= 1'b1;
			write_strobe_n <= 1'b1;
			byte_sel_n     <= 4'hF;
			write_byte_n   <= 4'hF;
			mem_data_oe    <= 1'b0;
		end else begin
			chip_select_n  <= cs_on ? ~(8'h01 << cur_cs) : 8'hFF;
			read_strobe_n  <= !(st_on && !cur_write);
			write_strobe_n <= !(st_on && cur_write && !cur_bat);
			byte_sel_n     <= (cs_on && !cur_bat) ? ~cur_be : 4'hF;
			write_byte_n   <= (st_on && cur_write && cur_bat)
				? ~cur_be : 4'hF;
			mem_data_oe    <= state == ST_RUN && cur_write;
		end
	end

endmodule
`default_nettype wire

/* dv/static_memory_page_read_ctrl_properties.sv */
// Concurrent checks on the ports of the static memory controller.
`timescale 1ns/1ps
`default_nettype none
module ctrl_checker (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic [7:0]                  paddr,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic                        slow_clock_mode,
	input wire logic                        other_access,
	input wire static_memory_pkg::mem_req_t req,
	input wire logic                        req_ready,
	input wire static_memory_pkg::mem_rsp_t rsp,
	input wire logic [7:0]                  chip_select_n,
	input wire logic                        read_strobe_n,
	input wire logic                        mem_data_oe
);
	import static_memory_pkg::*;
	// ****************************************
	// Port properties.
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_take;
		req.valid && req_ready;
	endsequence
	sequence s_slow_rd;
		s_take ##0 (!req.write && slow_clock_mode);
	endsequence
	sequence s_slow_wr;
		s_take ##0 (req.write && slow_clock_mode);
	endsequence
	property p_ready_now;
		psel && penable |-> pready;
	endproperty
	property p_unmapped_err;
		psel && penable && paddr > 8'h80 |-> pslverr;
	endproperty
	property p_mapped_ok;
		psel && penable && paddr <= 8'h80 |-> !pslverr;
	endproperty
	property p_rsp_single;
		rsp.valid |=> !rsp.valid;
	endproperty
	property p_one_at_time;
		s_take |=> !req_ready;
	endproperty
	property p_other_blocks;
		other_access |-> !req_ready;
	endproperty
	property p_slow_read;
		s_slow_rd |-> ##[2:4] rsp.valid;
	endproperty
	property p_slow_write;
		s_slow_wr |-> ##[3:5] rsp.valid;
	endproperty
	property p_rd_with_cs;
		!read_strobe_n |-> chip_select_n != 8'hFF;
	endproperty
	property p_oe_no_read;
		mem_data_oe |-> read_strobe_n;
	endproperty
	a_ready_now: assert property (p_ready_now)
		else $error("pready low in access phase");
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("no error on unmapped address");
	a_mapped_ok: assert property (p_mapped_ok)
		else $error("error on mapped address");
	a_rsp_single: assert property (p_rsp_single)
		else $error("response longer than one cycle");
	a_one_at_time: assert property (p_one_at_time)
		else $error("request taken while busy");
	a_other_blocks: assert property (p_other_blocks)
		else $error("request taken during other access");
	a_slow_read: assert property (p_slow_read)
		else $error("slow read length wrong");
	a_slow_write: assert property (p_slow_write)
		else $error("slow write length wrong");
	a_rd_with_cs: assert property (p_rd_with_cs)
		else $error("read strobe without chip select");
	a_oe_no_read: assert property (p_oe_no_read)
		else $error("data driven during read");
endmodule
bind static_memory_page_read_ctrl ctrl_checker u_checker (.pclk, .presetn,
	.psel, .penable, .paddr, .pready, .pslverr, .slow_clock_mode,
	.other_access, .req, .req_ready, .rsp, .chip_select_n, .read_strobe_n,
	.mem_data_oe);
`default_nettype wire

/* dv/page_memory_model.sv */
// Behavioural asynchronous page memory on the far side of the controller.
`timescale 1ns/1ps
`default_nettype none
module page_memory_model (
	input wire logic        pclk,
	input wire logic [7:0]  chip_select_n,
	input wire logic        read_strobe_n,
	input wire logic        write_strobe_n,
	input wire logic [3:0]  byte_sel_n,
	input wire logic [3:0]  write_byte_n,
	input wire logic [25:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic        mem_data_oe,
	input wire logic [3:0]  lat,
	output logic [31:0]     mem_rdata
);
	logic [31:0] store [logic [23:0]];
	logic [31:0] noise = 32'h5A5AA5A5;
	logic [25:0] last_addr;
	logic [31:0] w;
	int          age;
	// ****************************************
	// Storage and timing.
	// ****************************************
	// Data shows only after the access time; otherwise the bus churns.
	always @* begin
		if (chip_select_n != 8'hFF && !read_strobe_n && age >= lat) begin
			if (store.exists(mem_addr[25:2]))
				mem_rdata = store[mem_addr[25:2]];
			else
				mem_rdata = {6'h15, mem_addr[25:2], 2'b00};
		end else
			mem_rdata = noise;
	end
	// The device has no wait line, so it never stretches a page burst.
	always @(posedge pclk) begin
		noise <= ~noise;
		last_addr <= mem_addr;
		age <= (read_strobe_n || mem_addr != last_addr) ? 0 : age + 1;
		if (chip_select_n != 8'hFF && mem_data_oe) begin
			w = store.exists(mem_addr[25:2]) ? store[mem_addr[25:2]]
				: {6'h15, mem_addr[25:2], 2'b00};
			for (int i = 0; i < 4; i++) begin
				if ((!byte_sel_n[i] && !write_strobe_n) || !write_byte_n[i])
					w[8*i +: 8] = mem_wdata[8*i +: 8];
			end
			store[mem_addr[25:2]] = w;
		end
	end
endmodule
`default_nettype wire

/* dv/test_static_memory_page_read_ctrl.sv */
// Self-checking bench for the static memory page read controller.
`timescale 1ns/1ps
`default_nettype none
`include "static_memory_params.svh"
module test_static_memory_page_read_ctrl;
	import static_memory_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic        slow_clock_mode, other_access, req_ready, read_strobe_n;
	logic        write_strobe_n, mem_data_oe;
	logic [7:0]  paddr, chip_select_n;
	logic [31:0] pwdata, prdata, mem_wdata, mem_rdata, v;
	logic [3:0]  byte_sel_n, write_byte_n, lat;
	logic [25:0] mem_addr, base;
	mem_req_t    req;
	mem_rsp_t    rsp;
	logic [31:0] regs [32];
	logic [31:0] act [32];
	logic [31:0] model [logic [23:0]];
	logic [31:0] rv [4] = '{32'h0, 32'h01010101, 32'h00010001, 32'h10001000};
	int          bad_count, checks, cyc, pv, pcs, ppg, exp_low;
	static_memory_page_read_ctrl u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.slow_clock_mode, .other_access, .req, .req_ready, .rsp,
		.chip_select_n, .read_strobe_n, .write_strobe_n, .byte_sel_n,
		.write_byte_n, .mem_addr, .mem_wdata, .mem_data_oe, .mem_rdata);
	page_memory_model u_mem (.pclk, .chip_select_n, .read_strobe_n,
		.write_strobe_n, .byte_sel_n, .write_byte_n, .mem_addr,
		.mem_wdata, .mem_data_oe, .lat, .mem_rdata);
	// ****************************************
	// Clock, timeout and helpers.
	// ****************************************
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(bit wr, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (wr && a < 8'h80) regs[a[6:2]] = d;
		if (wr && a < 8'h80 && a[3:2] == 2'b11) act = regs;
	endtask
	task automatic cfg(int cs, logic [31:0] s, p, c, m);
		apb(1, 8'(cs * 16), s);
		apb(1, 8'(cs * 16 + 4), p);
		apb(1, 8'(cs * 16 + 8), c);
		apb(1, 8'(cs * 16 + 12), m);
	endtask
	function automatic int dec(logic [8:0] f, bit pulse);
		int n;
		n = pulse ? 256 * f[6] + f[5:0] : 256 * f[8:7] + f[6:0];
		return n < 1 ? 1 : n;
	endfunction
	function automatic int expect_lat(int cs, logic [25:0] a, bit wr);
		logic [31:0] m, p, c;
		int          pg, hit;
		m = act[cs * 4 + 3];
		p = act[cs * 4 + 1];
		c = act[cs * 4 + 2];
		exp_low = 0;
		pg = (a >> (2 + m[29:28])) << (2 + m[29:28]);
		hit = pv && pcs == cs && ppg == pg;
		if (slow_clock_mode || wr || !m[24]) begin
			pv = 0;
			if (slow_clock_mode)
				return wr ? `SLOW_WR_CYCLE + 2 : `SLOW_RD_CYCLE + 2;
			if (!wr) exp_low = dec({2'b0, p[22:16]}, 1);
			return dec(wr ? c[8:0] : c[24:16], 0) + 2;
		end
		pv = 1;
		pcs = cs;
		ppg = pg;
		return dec({2'b0, hit ? p[22:16] : p[30:24]}, 1) + 2;
	endfunction
	task automatic mem(int cs, logic [25:0] a, bit wr);
		int          n, low, ex;
		logic [31:0] d;
		d = $urandom;
		@(posedge pclk);
		req <= '{1'b1, wr, 3'(cs), a, 4'hF, d};
		do @(posedge pclk); while (req_ready !== 1'b1);
		ex = expect_lat(cs, a, wr);
		req.valid <= 1'b0;
		n = 0;
		low = 0;
		do begin
			@(posedge pclk);
			n++;
			low += (read_strobe_n === 1'b0);
		end while (rsp.valid !== 1'b1 && n < 1000);
		check("latency", n, ex);
		if (exp_low > 0) check("strobe", low, exp_low);
		if (wr) model[a[25:2]] = d;
		else check("rdata", rsp.rdata, model.exists(a[25:2]) ?
			model[a[25:2]] : {6'h15, a[25:2], 2'b00});
	endtask
	// ****************************************
	// Scenarios.
	// ****************************************
	initial begin
		{presetn, psel, penable, pwrite, slow_clock_mode, other_access} = 0;
		{paddr, pwdata, req, lat} = 0;
		v = $urandom(32'h7BCF2339);
		for (int i = 0; i < 32; i++) regs[i] = rv[i % 4];
		act = regs;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			apb(0, 8'(i * 4), 0);
			check("reset", v, rv[i % 4]);
		end
		apb(0, 8'h80, 0);
		check("status", v, 0);
		apb(1, 8'h84, 32'hFFFFFFFF);
		check("slverr", e, 1);
		apb(0, 8'h81, 0);
		check("unmapped", {v[30:0], e}, 1);
		for (int i = 8; i < 32; i++) begin
			apb(1, 8'(i * 4), $urandom);
			apb(0, 8'(i * 4), 0);
			check("readback", v, regs[i]);
		end
		base = 26'($urandom);
		mem(1, base, 1);
		mem(1, base, 0);
		apb(1, 8'h18, 32'h00050005);
		mem(1, base, 0);
		apb(1, 8'h1C, 32'h10001000);
		mem(1, base, 0);
		lat = 4'h3;
		cfg(1, 32'h21210000, 32'h41410101, 32'h01830003, 32'h10001000);
		mem(1, base, 0);
		lat = 4'h0;
		cfg(1, 0, 32'h01010101, 32'h00010001, 32'h10002100);
		mem(1, base + 8, 1);
		mem(1, base + 8, 0);
		for (int ps = 0; ps < 4; ps++) begin
			base = 26'(32 * ps + 32);
			cfg(0, 32'h3F3F0000, 32'h05020101, 32'h00C80003,
				32'h01002000 | (ps << 28));
			mem(0, base, 0);
			mem(0, base + (4 << ps) - 4, 0);
			mem(0, base + (4 << ps), 0);
			mem(0, base + (4 << ps) + 1, 0);
		end
		apb(0, 8'h80, 0);
		check("status", v, 32'h00000007);
		mem(1, base, 0);
		mem(0, base, 0);
		@(posedge pclk);
		other_access <= 1'b1;
		@(posedge pclk);
		other_access <= 1'b0;
		pv = 0;
		mem(0, base, 0);
		mem(0, base, 1);
		mem(0, base, 0);
		apb(1, 8'h04, 32'h01030101);
		apb(1, 8'h0C, 32'h11002000);
		mem(0, base, 0);
		mem(0, base + 8, 0);
		slow_clock_mode <= 1'b1;
		mem(0, base, 0);
		mem(0, base, 1);
		fork
			mem(0, base, 0);
			begin
				@(posedge pclk iff (req_ready === 1'b1 && req.valid === 1'b1));
				slow_clock_mode <= 1'b0;
			end
		join
		mem(0, base, 0);
		end_of_test();
	end
endmodule
`default_nettype wire
